// file: rtl/lsh_core.sv
// module: lin slave header detection, mute control and baud resynchronisation behind apb
// How it works
// [RULE1] header detect on: full break, sync, id sets detected flag; interrupt if enabled
// [RULE2] bad id parity with parity check on sets parity error and detected flags
// [RULE3] in mute only headers are detected; other bytes never reach the receive store
// [RULE4] header not complete within 57 bit times sets header error flag
// [RULE5] time-out runs from break; stops on id, header error or resync write
// [RULE6] break-only select: leave mute after break plus delimiter
// [RULE7] break-sync select: leave mute after break, delimiter and clean sync
// [RULE8] break-sync-id select: leave mute only when clean id matches expected id
// [RULE9] auto resync retunes the baud divisor after every sync field
// [RULE10] time five sync falling edges in 13 bits, load divisor at fifth
// [RULE11] sync timer overflow before fifth falling edge sets header error
// [RULE12] programmed divisor is saved as hidden initial value for reloads
// [RULE13] reload enable restores initial divisor on next byte, then clears itself
// [RULE14] software should set reload enable before each checksum byte
// [RULE15] software should enter mute after transmitting the checksum
// [RULE16] resync write after header error reloads initial divisor and restarts search
// [RULE17] auto resync needs both divider mode bits set by software; here the bits are only stored, auto resync follows its enable alone
// [RULE18] fixed baud setup: divisor, function, auto off, then slave enable
// [RULE19] auto baud setup: divisor, function, auto on, then slave enable
// [RULE20] published response goes through transmit data; subscribed response is received
// [RULE21] break is more than 11 dominant bits then recessive, flagged at break end
// [RULE22] delimiter shorter than half a bit sets header error flag
// [RULE23] header select chooses break, break plus sync, or full header
// [RULE24] status flags stay set until software writes 1 to clear
// [RULE25] header detect off: no detected or parity flags, time-out idle
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module lsh_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line,
  output logic lin_irq,
  output logic rx_store_valid,
  output logic [7:0] rx_store_data,
  output logic tx_load,
  output logic [7:0] tx_data,
  output logic [15:0] baud_divisor
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic slave_mode_enable_r;
  logic slave_header_detect_enable_r;
  logic id_parity_enable_r;
  logic auto_resync_enable_r;
  logic mute_r;
  logic [1:0] head_sel_r;
  logic baud_reload_enable_r;
  logic bus_event_interrupt_enable_r;
  logic [7:0] expected_protected_id_r;
  logic slave_header_detected_flag_r;
  logic id_parity_error_flag_r;
  logic header_error_flag_r;
  logic baud_x_en_r;
  logic baud_x_one_r;
  logic [15:0] init_div_r;
  logic [7:0] last_rx_r;
  lsh_pkg::lsh_hdr_t state_r;
  lsh_pkg::lsh_hdr_t state_nxt;
  logic line_q_r;
  logic [15:0] low_cyc_r;
  logic [4:0] low_bits_r;
  logic [15:0] dl_cyc_r;
  logic tmo_on_r;
  logic [15:0] tmo_cyc_r;
  logic [5:0] tmo_bits_r;
  logic meas_on_r;
  logic [2:0] edge_cnt_r;
  logic [12:0] meas_r;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_fe;
  logic acc;
  logic wr_en;
  logic rs_wr;
  logic clr_wr;
  logic hdr_on;
  logic fall;
  logic rise;
  logic brk_det;
  logic tmo_hit;
  logic meas_ovf;
  logic sync_load;
  logic [15:0] sync_div;
  logic herr_evt;
  logic hdet_evt;
  logic idperr_evt;
  logic mute_exit;

  // engine idle during an auto sync: the old divisor would misframe it
  lsh_rx_byte u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .rx_line(rx_line || (auto_resync_enable_r && state_r == lsh_pkg::ST_SYNC)),
    .divisor(baud_divisor),
    .byte_valid(rx_valid),
    .byte_data(rx_data),
    .frame_err(rx_fe)
  );

  // ----------------------------------------------------------------------
  // apb slave: one wait state so read data comes from a flip-flop
  // ----------------------------------------------------------------------
  assign acc = psel && penable && pready;
  assign wr_en = acc && pwrite;
  assign clr_wr = wr_en && (paddr == lsh_pkg::ADDR_STAT);
  assign rs_wr = clr_wr && pwdata[lsh_pkg::S_RSYNC];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        if (paddr == lsh_pkg::ADDR_CTRL) begin
          prdata[lsh_pkg::C_SLV] <= slave_mode_enable_r;
          prdata[lsh_pkg::C_HDET] <= slave_header_detect_enable_r;
          prdata[lsh_pkg::C_IDP] <= id_parity_enable_r;
          prdata[lsh_pkg::C_ARS] <= auto_resync_enable_r;
          prdata[lsh_pkg::C_MUTE] <= mute_r;
          prdata[lsh_pkg::C_HSEL +: 2] <= head_sel_r;
          prdata[lsh_pkg::C_RLD] <= baud_reload_enable_r;
          prdata[lsh_pkg::C_IEN] <= bus_event_interrupt_enable_r;
          prdata[lsh_pkg::C_PID +: 8] <= expected_protected_id_r;
        end else if (paddr == lsh_pkg::ADDR_STAT) begin
          prdata[lsh_pkg::S_HDET] <= slave_header_detected_flag_r;
          prdata[lsh_pkg::S_IDPE] <= id_parity_error_flag_r;
          prdata[lsh_pkg::S_HERR] <= header_error_flag_r;
          prdata[lsh_pkg::S_STATE +: 5] <= state_r;
        end else if (paddr == lsh_pkg::ADDR_BAUD) begin
          prdata[15:0] <= baud_divisor;
          prdata[lsh_pkg::B_XONE] <= baud_x_one_r;
          prdata[lsh_pkg::B_XEN] <= baud_x_en_r;
        end else if (paddr == lsh_pkg::ADDR_TXD) begin
          prdata[7:0] <= tx_data;
        end else if (paddr == lsh_pkg::ADDR_RXD) begin
          prdata[7:0] <= last_rx_r;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // control register; hardware clears mute and reload, a write overrides
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_mode_enable_r <= 1'b0;
      slave_header_detect_enable_r <= 1'b0;
      id_parity_enable_r <= 1'b0;
      auto_resync_enable_r <= 1'b0;
      mute_r <= 1'b0;
      head_sel_r <= lsh_pkg::HSEL_BRK;
      baud_reload_enable_r <= 1'b0;
      bus_event_interrupt_enable_r <= 1'b0;
      expected_protected_id_r <= 8'h00;
    end else begin
      if (mute_exit) begin
        mute_r <= 1'b0; // [RULE6] [RULE7] [RULE8]
      end
      if (baud_reload_enable_r && rx_valid) begin
        baud_reload_enable_r <= 1'b0; // [RULE13]
      end
      if (wr_en && paddr == lsh_pkg::ADDR_CTRL) begin
        slave_mode_enable_r <= pwdata[lsh_pkg::C_SLV]; // [RULE18] [RULE19]
        slave_header_detect_enable_r <= pwdata[lsh_pkg::C_HDET];
        id_parity_enable_r <= pwdata[lsh_pkg::C_IDP];
        auto_resync_enable_r <= pwdata[lsh_pkg::C_ARS];
        mute_r <= pwdata[lsh_pkg::C_MUTE]; // [RULE15]
        head_sel_r <= pwdata[lsh_pkg::C_HSEL +: 2]; // [RULE23]
        baud_reload_enable_r <= pwdata[lsh_pkg::C_RLD]; // [RULE14]
        bus_event_interrupt_enable_r <= pwdata[lsh_pkg::C_IEN];
        expected_protected_id_r <= pwdata[lsh_pkg::C_PID +: 8];
      end
    end
  end

  // ----------------------------------------------------------------------
  // baud divisor, hidden initial value and automatic loads
  // ----------------------------------------------------------------------
  // measured span is eight bit times, so one bit is the span shifted down
  assign sync_div = ({3'h0, meas_r} + 16'h0001) >> lsh_pkg::MEAS_SHIFT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_divisor <= lsh_pkg::BAUD_RST;
      init_div_r <= lsh_pkg::BAUD_RST;
      baud_x_en_r <= 1'b0;
      baud_x_one_r <= 1'b0;
    end else begin
      if (wr_en && paddr == lsh_pkg::ADDR_BAUD) begin
        // saved on every write: setup programs the divisor before auto mode is on
        baud_divisor <= pwdata[15:0];
        init_div_r <= pwdata[15:0]; // [RULE12]
        baud_x_en_r <= pwdata[lsh_pkg::B_XEN]; // [RULE17]
        baud_x_one_r <= pwdata[lsh_pkg::B_XONE];
      end
      if (rs_wr || (baud_reload_enable_r && rx_valid)) begin
        baud_divisor <= init_div_r; // [RULE13] [RULE16]
      end
      if (sync_load) begin
        baud_divisor <= sync_div; // [RULE9] [RULE10]
      end
    end
  end

  // ----------------------------------------------------------------------
  // line watch: dominant length, delimiter length, time-out, sync timer
  // ----------------------------------------------------------------------
  assign hdr_on = slave_mode_enable_r && slave_header_detect_enable_r;
  assign fall = line_q_r && !rx_line;
  assign rise = !line_q_r && rx_line;
  assign brk_det = hdr_on && rise && (low_bits_r >= lsh_pkg::BRK_MIN_BITS) && (state_r != lsh_pkg::ST_ERR); // [RULE21]
  assign tmo_hit = tmo_on_r && (tmo_bits_r == lsh_pkg::TMO_BITS); // [RULE4]
  assign meas_ovf = meas_on_r && (meas_r == lsh_pkg::MEAS_MAX); // [RULE11]
  assign sync_load = hdr_on && auto_resync_enable_r && !rs_wr && !brk_det && !tmo_hit && (state_r == lsh_pkg::ST_SYNC)
    && fall && meas_on_r && (edge_cnt_r == lsh_pkg::EDGE_LAST); // [RULE10]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q_r <= 1'b1;
      low_cyc_r <= 16'h0000;
      low_bits_r <= 5'h00;
      dl_cyc_r <= 16'h0000;
    end else begin
      line_q_r <= rx_line;
      if (rx_line) begin
        low_cyc_r <= 16'h0000;
        low_bits_r <= 5'h00;
      end else if (low_cyc_r >= baud_divisor - 16'h0001) begin
        low_cyc_r <= 16'h0000;
        if (low_bits_r != lsh_pkg::LOW_BITS_MAX) begin
          low_bits_r <= low_bits_r + 5'h01;
        end
      end else begin
        low_cyc_r <= low_cyc_r + 16'h0001;
      end
      dl_cyc_r <= (state_r == lsh_pkg::ST_DELIM) ? dl_cyc_r + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_on_r <= 1'b0;
      tmo_cyc_r <= 16'h0000;
      tmo_bits_r <= 6'h00;
    end else if (!hdr_on || rs_wr || herr_evt || hdet_evt) begin
      tmo_on_r <= 1'b0; // [RULE5] [RULE25]
    end else if (brk_det) begin
      tmo_on_r <= 1'b1; // [RULE5]
      tmo_cyc_r <= 16'h0000;
      tmo_bits_r <= 6'h00;
    end else if (tmo_on_r) begin
      if (tmo_cyc_r >= baud_divisor - 16'h0001) begin
        tmo_cyc_r <= 16'h0000;
        tmo_bits_r <= tmo_bits_r + 6'h01;
      end else begin
        tmo_cyc_r <= tmo_cyc_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_on_r <= 1'b0;
      edge_cnt_r <= 3'h0;
      meas_r <= 13'h0000;
    end else if (state_r != lsh_pkg::ST_SYNC || !auto_resync_enable_r) begin
      meas_on_r <= 1'b0;
      edge_cnt_r <= 3'h0;
      meas_r <= 13'h0000;
    end else if (fall && !meas_on_r && edge_cnt_r == 3'h0) begin
      meas_on_r <= 1'b1;
      edge_cnt_r <= 3'h1;
    end else if (fall && meas_on_r) begin
      meas_on_r <= (edge_cnt_r != lsh_pkg::EDGE_LAST);
      edge_cnt_r <= edge_cnt_r + 3'h1;
      meas_r <= meas_r + 13'h0001;
    end else if (meas_on_r && meas_r != lsh_pkg::MEAS_MAX) begin
      meas_r <= meas_r + 13'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // header sequence
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    herr_evt = 1'b0;
    hdet_evt = 1'b0;
    idperr_evt = 1'b0;
    mute_exit = 1'b0;
    if (!hdr_on || rs_wr) begin
      state_nxt = lsh_pkg::ST_IDLE; // [RULE16] [RULE25]
    end else if (brk_det) begin
      state_nxt = lsh_pkg::ST_DELIM;
    end else if (tmo_hit) begin
      herr_evt = 1'b1;
      state_nxt = lsh_pkg::ST_ERR;
    end else begin
      case (state_r)
        lsh_pkg::ST_DELIM: begin
          if (fall) begin
            herr_evt = 1'b1; // [RULE22]
            state_nxt = lsh_pkg::ST_ERR;
          end else if (dl_cyc_r >= (baud_divisor >> 1)) begin
            state_nxt = lsh_pkg::ST_SYNC;
            mute_exit = (head_sel_r == lsh_pkg::HSEL_BRK); // [RULE6]
          end
        end
        lsh_pkg::ST_SYNC: begin
          if (meas_ovf) begin
            herr_evt = 1'b1; // [RULE11]
            state_nxt = lsh_pkg::ST_ERR;
          end else if (auto_resync_enable_r ? rise && edge_cnt_r > lsh_pkg::EDGE_LAST : rx_valid) begin
            if (!auto_resync_enable_r && (rx_fe || rx_data != lsh_pkg::SYNC_BYTE)) begin
              herr_evt = 1'b1;
              state_nxt = lsh_pkg::ST_ERR;
            end else begin
              state_nxt = lsh_pkg::ST_PID;
              mute_exit = (head_sel_r == lsh_pkg::HSEL_SYNC); // [RULE7]
            end
          end
        end
        lsh_pkg::ST_PID: begin
          if (rx_valid) begin
            if (rx_fe) begin
              herr_evt = 1'b1;
              state_nxt = lsh_pkg::ST_ERR;
            end else begin
              hdet_evt = 1'b1; // [RULE1]
              idperr_evt = id_parity_enable_r && !lsh_pkg::lsh_pid_ok(rx_data); // [RULE2]
              state_nxt = lsh_pkg::ST_IDLE;
              mute_exit = (head_sel_r == lsh_pkg::HSEL_ID) && (rx_data == expected_protected_id_r)
                && !idperr_evt; // [RULE8]
            end
          end
        end
        lsh_pkg::ST_IDLE: begin
          state_nxt = lsh_pkg::ST_IDLE;
        end
        lsh_pkg::ST_ERR: begin
          state_nxt = lsh_pkg::ST_ERR;
        end
        default: begin
          state_nxt = lsh_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= lsh_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // sticky flags: a hardware set in the clearing cycle wins
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_header_detected_flag_r <= 1'b0;
      id_parity_error_flag_r <= 1'b0;
      header_error_flag_r <= 1'b0;
      lin_irq <= 1'b0;
    end else begin
      slave_header_detected_flag_r <= (slave_header_detected_flag_r && !(clr_wr && pwdata[lsh_pkg::S_HDET]))
        || hdet_evt || idperr_evt; // [RULE24] [RULE1] [RULE2]
      id_parity_error_flag_r <= (id_parity_error_flag_r && !(clr_wr && pwdata[lsh_pkg::S_IDPE]))
        || idperr_evt; // [RULE24]
      header_error_flag_r <= (header_error_flag_r && !(clr_wr && pwdata[lsh_pkg::S_HERR]))
        || herr_evt; // [RULE24] [RULE4]
      lin_irq <= bus_event_interrupt_enable_r
        && (slave_header_detected_flag_r || id_parity_error_flag_r || header_error_flag_r); // [RULE1]
    end
  end

  // ----------------------------------------------------------------------
  // data paths to the host uart
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_store_valid <= 1'b0;
      rx_store_data <= 8'h00;
      last_rx_r <= 8'h00;
      tx_load <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      // mute_r is the value before this byte, so the byte that ends mute is not stored
      rx_store_valid <= rx_valid && !mute_r; // [RULE3] [RULE20]
      if (rx_valid) begin
        rx_store_data <= rx_data;
        last_rx_r <= rx_data;
      end
      tx_load <= wr_en && (paddr == lsh_pkg::ADDR_TXD); // [RULE20]
      if (wr_en && paddr == lsh_pkg::ADDR_TXD) begin
        tx_data <= pwdata[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/lsh_pkg.sv
// package: register map, field positions, header timing and state codes for the lin slave header block
package lsh_pkg;

  // ----------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_TXD = 8'h0c;
  localparam logic [7:0] ADDR_RXD = 8'h10;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int C_SLV = 0;
  localparam int C_HDET = 1;
  localparam int C_IDP = 2;
  localparam int C_ARS = 3;
  localparam int C_MUTE = 4;
  localparam int C_HSEL = 5;
  localparam int C_RLD = 7;
  localparam int C_IEN = 8;
  localparam int C_PID = 16;
  localparam int S_HDET = 0;
  localparam int S_IDPE = 1;
  localparam int S_HERR = 2;
  localparam int S_RSYNC = 3;
  localparam int S_STATE = 8;
  localparam int B_XONE = 28;
  localparam int B_XEN = 29;

  // ----------------------------------------------------------------------
  // reset values, encodings and counts
  // ----------------------------------------------------------------------
  localparam logic [15:0] BAUD_RST = 16'h0010;
  localparam logic [1:0] HSEL_BRK = 2'h0;
  localparam logic [1:0] HSEL_SYNC = 2'h1;
  localparam logic [1:0] HSEL_ID = 2'h2;
  localparam logic [4:0] BRK_MIN_BITS = 5'h0c;
  localparam logic [4:0] LOW_BITS_MAX = 5'h1f;
  localparam logic [5:0] TMO_BITS = 6'h39;
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [2:0] EDGE_LAST = 3'h4;
  localparam logic [12:0] MEAS_MAX = 13'h1fff;
  localparam int MEAS_SHIFT = 3;
  localparam logic [3:0] RX_LAST_DATA = 4'h8;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DELIM = 5'b00010,
    ST_SYNC = 5'b00100,
    ST_PID = 5'b01000,
    ST_ERR = 5'b10000
  } lsh_hdr_t;

  // protected id: two parity bits over the six id bits
  function automatic logic lsh_pid_ok(input logic [7:0] p);
    logic p0;
    logic p1;
    p0 = p[0] ^ p[1] ^ p[2] ^ p[4];
    p1 = ~(p[1] ^ p[3] ^ p[4] ^ p[5]);
    return (p[6] == p0) && (p[7] == p1);
  endfunction

endpackage

// file: rtl/lsh_rx_byte.sv
// module: mid-bit sampling byte receiver used for header fields
`timescale 1ns/1ps
`default_nettype none
module lsh_rx_byte (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_line,
  input wire logic [15:0] divisor,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic frame_err
);
  logic busy_r;
  logic wait_hi_r;
  logic line_q_r;
  logic [15:0] cnt_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  localparam logic [3:0] RX_LAST_DATA_L = lsh_pkg::RX_LAST_DATA;

  // ----------------------------------------------------------------------
  // receive engine
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      wait_hi_r <= 1'b0;
      line_q_r <= 1'b1;
      cnt_r <= 16'h0000;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      frame_err <= 1'b0;
    end else begin
      line_q_r <= rx_line;
      byte_valid <= 1'b0;
      if (!busy_r) begin
        // after a low stop bit (a break) wait for recessive before the next start
        if (wait_hi_r) begin
          if (rx_line) begin
            wait_hi_r <= 1'b0;
          end
        end else if (line_q_r && !rx_line) begin
          busy_r <= 1'b1;
          cnt_r <= divisor >> 1;
          bit_r <= 4'h0;
        end
      end else if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end else begin
        cnt_r <= divisor - 16'h0001;
        if (bit_r == 4'h0) begin
          if (rx_line) begin
            busy_r <= 1'b0;
          end else begin
            bit_r <= 4'h1;
          end
        end else if (bit_r <= RX_LAST_DATA_L) begin
          shift_r <= {rx_line, shift_r[7:1]};
          bit_r <= bit_r + 4'h1;
        end else begin
          byte_valid <= 1'b1;
          byte_data <= shift_r;
          frame_err <= !rx_line;
          wait_hi_r <= !rx_line;
          busy_r <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/lsh_core_properties.sv
// checker: port-level properties of the lin slave header block
`timescale 1ns/1ps
`default_nettype none
module lsh_core_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_line,
  input wire logic lin_irq,
  input wire logic rx_store_valid,
  input wire logic [7:0] rx_store_data,
  input wire logic tx_load,
  input wire logic [7:0] tx_data,
  input wire logic [15:0] baud_divisor
);
  // ----
  // bus answer and pulse properties
  // ----
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic done = psel && penable && pready;
  wait_state_a: assert property (psel && !penable |-> ##2 pready) else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held past one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  err_map_a: assert property (done |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
    else $error("slave error does not match address map");
  tx_write_a: assert property (done && pwrite && paddr == 8'h0c |=> tx_load && {24'h0, tx_data} == ($past(pwdata) & 32'hff))
    else $error("transmit byte not loaded");
  tx_pulse_a: assert property (tx_load |=> !tx_load) else $error("transmit load longer than one cycle");
  store_pulse_a: assert property (rx_store_valid |=> !rx_store_valid) else $error("store strobe too long");
  baud_write_a: assert property (done && pwrite && paddr == 8'h08 |=> {16'h0, baud_divisor} == ($past(pwdata) & 32'hffff))
    else $error("divisor write lost");
endmodule
bind lsh_core lsh_core_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_line(rx_line), .lin_irq(lin_irq), .rx_store_valid(rx_store_valid), .rx_store_data(rx_store_data),
  .tx_load(tx_load), .tx_data(tx_data), .baud_divisor(baud_divisor));
`default_nettype wire

// file: tb/lsh_lin_master.sv
// model: lin master node driving the slave receive line
`timescale 1ns/1ps
`default_nettype none
module lsh_lin_master (
  input wire logic pclk,
  output var logic rx_line
);
  // bus has a pull-up: recessive whenever nothing is sent
  initial rx_line = 1'b1;
  task automatic hold(input logic v, input int cyc);
    rx_line <= v;
    repeat (cyc) @(posedge pclk);
  endtask
  task automatic brk(input int bt, input int dl);
    hold(1'b0, 13 * bt);
    hold(1'b1, dl);
  endtask
  // 8n1, lsb first
  task automatic tx(input logic [7:0] b, input int bt);
    hold(1'b0, bt);
    for (int i = 0; i < 8; i++) hold(b[i], bt);
    hold(1'b1, bt);
  endtask
endmodule
`default_nettype wire

// file: tb/test_lsh_core.sv
// testbench: register, header, mute and resync scenarios for the lin slave header block
`timescale 1ns/1ps
`default_nettype none
module test_lsh_core;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic pready, pslverr, lin_irq, rx_store_valid, tx_load;
  logic [7:0] paddr = 8'h00, rx_store_data, tx_data, pid;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] baud_divisor;
  logic [5:0] id;
  wire logic rx_line;
  int error_cnt = 0, compares = 0, stored = 0, bt;
  int exp_st [4] = '{3, 2, 1, 0};
  lsh_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
    .lin_irq(lin_irq), .rx_store_valid(rx_store_valid), .rx_store_data(rx_store_data), .tx_load(tx_load),
    .tx_data(tx_data), .baud_divisor(baud_divisor));
  lsh_lin_master u_lin (.pclk(pclk), .rx_line(rx_line));
  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) if (rx_store_valid === 1'b1) stored++;
  // ----
  // helpers
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // called at a rising edge; returns one edge after the release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stat(input logic [31:0] e);
    apb(1'b0, lsh_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h7, e);
  endtask
  task automatic header(input logic [7:0] p, input int b);
    u_lin.brk(b, b);
    u_lin.tx(8'h55, b);
    u_lin.tx(p, b);
    repeat (4) @(posedge pclk);
  endtask
  function automatic logic [7:0] mkpid(input logic [5:0] i);
    mkpid = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction
  function automatic logic [31:0] ctl(input logic [1:0] hs, input logic mu, input logic ar, input logic [7:0] p);
    ctl = {8'h0, p, 7'h0, 1'b1, 1'b0, hs, mu, ar, 3'h7};
  endfunction
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    report_and_stop;
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(19119));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    check(baud_divisor, 32'h10);
    @(posedge pclk);
    apb(1'b1, lsh_pkg::ADDR_BAUD, 32'h30000010);
    apb(1'b0, 8'h14, 32'h0);
    check({rd[31:1], err}, 32'h1);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      id = 6'($urandom);
      pid = mkpid(id);
      apb(1'b1, lsh_pkg::ADDR_CTRL, ctl(m == 3 ? 2'h2 : 2'(m), 1'b1, 1'b0, pid ^ {7'h0, m == 3}));
      stored = 0;
      header(pid, 16);
      u_lin.tx(8'($urandom), 16);
      check(stored, exp_st[m]);
      stat(32'h1);
      check(lin_irq, 1'b1);
      apb(1'b1, lsh_pkg::ADDR_STAT, 32'h7);
      stat(32'h0);
      check(lin_irq, 1'b0);
    end
    $display("test mute exits done");
    apb(1'b1, lsh_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 8'h0));
    header(mkpid(id) ^ 8'h80, 16);
    stat(32'h3);
    apb(1'b1, lsh_pkg::ADDR_STAT, 32'h7);
    apb(1'b1, lsh_pkg::ADDR_CTRL, 32'h1);
    header(mkpid(id) ^ 8'h80, 16);
    stat(32'h0);
    $display("test parity done");
    bt = 20 + int'($urandom % 12);
    apb(1'b1, lsh_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b1, 8'h0));
    header(mkpid(id), bt);
    check(baud_divisor, bt);
    u_lin.brk(bt, bt);
    repeat (40 * bt) @(posedge pclk);
    stat(32'h1);
    repeat (20 * bt) @(posedge pclk);
    apb(1'b0, lsh_pkg::ADDR_STAT, 32'h0);
    check(rd & 32'h1f07, 32'h1005);
    apb(1'b1, lsh_pkg::ADDR_STAT, 32'hf);
    check(baud_divisor, 32'h10);
    header(mkpid(id), bt);
    apb(1'b1, lsh_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b1, 8'h0) | 32'h80);
    u_lin.tx(8'h3c, bt);
    check(baud_divisor, 32'h10);
    apb(1'b0, lsh_pkg::ADDR_CTRL, 32'h0);
    check(rd & 32'h80, 32'h0);
    $display("test resync done");
    apb(1'b1, lsh_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 1'b0, 8'h0));
    u_lin.brk(16, 4);
    u_lin.tx(8'h00, 16);
    stat(32'h5);
    apb(1'b1, lsh_pkg::ADDR_TXD, {24'h0, pid});
    check(tx_data, pid);
    $display("test delimiter and transmit done");
    report_and_stop;
  end
endmodule
`default_nettype wire
